// ---- bench/testbench.sv ----
// self-checking bench for the channel and pin register bank
// assumes the design's ahb-lite slave with hready tied back from hreadyout
`timescale 1ns/1ps
module testbench;
  localparam logic [15:0] IDENT_CODE = 16'h5A3C; // arbitrary value
  localparam int CONV = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans, gp_in, gp_out, gp_oe_n;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdat;
  adc_regs_pkg::conv_sel_t conv_sel;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int seen0, seen3;

  adc_channel_gpio_registers #(.IDENTITY_CODE(IDENT_CODE), .CONV_CYCLES(CONV)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gp_in(gp_in),
    .gp_out(gp_out), .gp_oe_n(gp_oe_n), .conv_sel(conv_sel));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus access, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {idx[5:0], 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), rdat, exp);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    gp_in = 2'b00;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and fixed code
    rd(8'h10, 32'h8001);
    for (int i = 1; i < 16; i++) rd(8'h10 + i[7:0], 32'h0001);
    rd(8'h06, 32'h0);
    chk("gp_oe_n", {30'h0, gp_oe_n}, 32'h3);
    bus(1'b1, 8'h07, 32'h0000FFFF);
    rd(8'h07, {16'h0, IDENT_CODE});
    bus(1'b1, 8'h08, 32'h0000FFFF);
    rd(8'h08, 32'h0);
    $display("test reset and identity done");
    // pin control
    bus(1'b1, 8'h06, 32'h0000000A);
    repeat (3) @(posedge hclk);
    chk("gp_oe_n", {30'h0, gp_oe_n}, 32'h1);
    chk("gp_out", {30'h0, gp_out}, 32'h2);
    gp_in <= 2'b10;
    bus(1'b1, 8'h06, 32'h00000035);
    rd(8'h06, 32'h36);
    chk("gp_oe_n", {30'h0, gp_oe_n}, 32'h2);
    chk("gp_out", {30'h0, gp_out}, 32'h1);
    $display("test pins done");
    // channel fields, reserved bits, every setup code
    bus(1'b1, 8'h11, 32'hFFFFFFFF);
    rd(8'h11, 32'hF3FF);
    bus(1'b1, 8'h11, 32'h00000001);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 8'h18 + k[7:0], {17'h0, k[2:0], 2'b11, 10'h3FF});
      rd(8'h18 + k[7:0], {17'h0, k[2:0], 12'h3FF});
    end
    $display("test channel fields done");
    // scan over channels zero and three
    bus(1'b1, 8'h13, 32'h0000A005);
    seen0 = 0;
    seen3 = 0;
    repeat (12 * CONV) begin
      @(posedge hclk);
      if (conv_sel.valid === 1'b1) begin
        if (conv_sel.channel === 4'd0) seen0++;
        else seen3++;
        chk("conv_sel", {14'h0, conv_sel}, (conv_sel.channel === 4'd0) ?
          {14'h0, 1'b1, 4'd0, 3'd0, 10'h001} : {14'h0, 1'b1, 4'd3, 3'd2, 10'h005});
      end
    end
    chk("both scanned", {30'h0, seen0 > 0, seen3 > 0}, 32'h3);
    bus(1'b1, 8'h10, 32'h0000A001);
    repeat (CONV + 1) @(posedge hclk);
    repeat (4 * CONV) begin
      @(posedge hclk);
      chk("shared setup", {28'h0, conv_sel.valid, conv_sel.setup}, 32'hA);
    end
    bus(1'b1, 8'h10, 32'h00000001);
    bus(1'b1, 8'h13, 32'h00002005);
    repeat (3 * CONV) @(posedge hclk);
    chk("scan idle", {31'h0, conv_sel.valid}, 32'h0);
    $display("test scan done");
    // second reset in mid-run
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h10, 32'h8001);
    rd(8'h13, 32'h0001);
    rd(8'h06, 32'h0);
    chk("gp_oe_n", {30'h0, gp_oe_n}, 32'h3);
    $display("test second reset done");
    close_out();
  end
endmodule

// ---- logic/adc_channel_gpio_registers.sv ----
// pin control, identity and channel registers behind an ahb-lite slave,
// with a simple scan over enabled channels
// assumes one clock, hready wired back from hreadyout, word transfers only
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "adc_regs_defines.svh"

// Operation
// - bits 5,4 make pin one/zero inputs
// - bits 3,2 make pin one/zero outputs
// - bits 1,0 drive or read back pins
// - identity register, read-only fixed code
// - sixteen channel registers at 0x10..0x1F
// - enabled channels are sequenced automatically
// - channel zero resets 0x8001, others 0x0001
// - bits 14:12 select one of eight setups
// - chosen setup applies to channel conversions
// - bits 9:0 select the input pair
module adc_channel_gpio_registers #(
  parameter int ADDR_W = 8,
  parameter logic [15:0] IDENTITY_CODE = 16'hA5C3, // arbitrary value
  parameter int CONV_CYCLES = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // general pins
  input wire logic [1:0] gp_in,
  output logic [1:0] gp_out,
  output logic [1:0] gp_oe_n,
  // converter selection
  output adc_regs_pkg::conv_sel_t conv_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_chan(input logic [7:0] index);
    is_chan = (index >= `IDX_CHAN_FIRST) && (index <= `IDX_CHAN_LAST);
  endfunction

  function automatic logic [4:0] next_enabled(input logic [3:0] cur,
                                              input logic [15:0] en);
    logic [4:0] result;
    logic [3:0] cand;
    result = 5'h00;
    cand = 4'h0;
    for (int k = `CHAN_COUNT; k >= 1; k--) begin
      cand = cur + k[3:0];
      if (en[cand]) begin
        result = {1'b1, cand};
      end
    end
    next_enabled = result;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage

  adc_regs_pkg::pin_ctrl_t pin_ctrl;
  adc_regs_pkg::channel_cfg_t chan [`CHAN_COUNT];
  adc_regs_pkg::bus_req_t req;
  adc_regs_pkg::bus_state_t bus_state;
  logic [1:0] pin_sample;
  logic [15:0] chan_en;
  logic [4:0] next_pick;
  logic [15:0] conv_timer;
  logic accept;
  logic [7:0] addr_index;
  logic [3:0] chan_slot;
  logic [31:0] read_word;
  logic first_cycle;

  assign addr_index = 8'(haddr[ADDR_W-1:`WORD_LSB]);
  assign accept = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];
  assign chan_slot = req.index[3:0];

  always_comb begin
    for (int i = 0; i < `CHAN_COUNT; i++) begin
      chan_en[i] = chan[i].enable;
    end
  end

  assign next_pick = next_enabled(conv_sel.channel, chan_en);

  ////////////////////////////////////////////////////////////////////////////
  // bus phases

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= adc_regs_pkg::BUS_IDLE;
      req <= '0;
    end else if (accept) begin
      bus_state <= hwrite ? adc_regs_pkg::BUS_WRITE : adc_regs_pkg::BUS_READ;
      req <= {hwrite, addr_index};
    end else begin
      bus_state <= adc_regs_pkg::BUS_IDLE;
    end
  end

  // reads take one wait cycle, writes none
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(accept && !hwrite);
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    read_word = 32'h0000_0000;
    if (req.index == `IDX_PIN_CTRL) begin
      read_word[5:2] = {pin_ctrl.in_en, pin_ctrl.out_en};
      for (int p = 0; p < 2; p++) begin
        read_word[p] = pin_ctrl.in_en[p] ? pin_sample[p] : pin_ctrl.level[p];
      end
    end else if (req.index == `IDX_IDENTITY) begin
      read_word[15:0] = IDENTITY_CODE;
    end else if (is_chan(req.index)) begin
      read_word[15:0] = chan[chan_slot] & `CHAN_WR_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == adc_regs_pkg::BUS_READ) begin
      hrdata <= read_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin control register and pins

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ctrl <= `PIN_CTRL_RESET;
    end else if (bus_state == adc_regs_pkg::BUS_WRITE && req.index == `IDX_PIN_CTRL) begin
      pin_ctrl <= hwdata[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sample <= 2'h0;
    end else begin
      pin_sample <= gp_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gp_out <= 2'h0;
      gp_oe_n <= 2'h3;
    end else begin
      gp_out <= pin_ctrl.level;
      gp_oe_n <= ~pin_ctrl.out_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel registers

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan[0] <= `CHAN0_RESET;
      for (int i = 1; i < `CHAN_COUNT; i++) begin
        chan[i] <= `CHANX_RESET;
      end
    end else if (bus_state == adc_regs_pkg::BUS_WRITE && is_chan(req.index)) begin
      chan[chan_slot] <= hwdata[15:0] & `CHAN_WR_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel scan

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_timer <= 16'h0000;
    end else if (conv_timer == 16'h0000) begin
      conv_timer <= 16'(CONV_CYCLES - 1);
    end else begin
      conv_timer <= conv_timer - 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_sel <= '0;
    end else if (conv_timer == 16'h0000) begin
      conv_sel.valid <= next_pick[4];
      conv_sel.channel <= next_pick[3:0];
      conv_sel.setup <= chan[next_pick[3:0]].setup;
      conv_sel.input_pair <= chan[next_pick[3:0]].input_pair;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_input_readback;
    (bus_state == adc_regs_pkg::BUS_READ && req.index == `IDX_PIN_CTRL
      && pin_ctrl.in_en[1])
      |=> hrdata[1] == $past(pin_sample[1]) && hrdata[5] && hreadyout;
  endproperty
  a_input_readback: assert property (p_input_readback)
    else $error("pin one input readback wrong");

  property p_output_enable;
    ##1 gp_oe_n == ~$past(pin_ctrl.out_en);
  endproperty
  a_output_enable: assert property (p_output_enable)
    else $error("pin output enable does not follow control");

  property p_pin_level;
    (bus_state == adc_regs_pkg::BUS_WRITE && req.index == `IDX_PIN_CTRL)
      |=> ##1 gp_out == $past(hwdata[1:0], 2);
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("written pin level not driven");

  property p_identity;
    (bus_state == adc_regs_pkg::BUS_READ && req.index == `IDX_IDENTITY)
      |=> hrdata == {16'h0000, IDENTITY_CODE};
  endproperty
  a_identity: assert property (p_identity)
    else $error("identity read wrong");

  property p_chan_write;
    (bus_state == adc_regs_pkg::BUS_WRITE && is_chan(req.index))
      |=> chan[$past(chan_slot)] == ($past(hwdata[15:0]) & `CHAN_WR_MASK);
  endproperty
  a_chan_write: assert property (p_chan_write)
    else $error("channel write not stored");

  property p_scan_enabled;
    (conv_sel.valid && $changed(conv_sel.channel))
      |-> (($past(chan_en) >> conv_sel.channel) & 16'h0001) != 16'h0000;
  endproperty
  a_scan_enabled: assert property (p_scan_enabled)
    else $error("scan picked a disabled channel");

  property p_reset_values;
    first_cycle |-> chan[0] == `CHAN0_RESET && chan[1] == `CHANX_RESET
      && chan[15] == `CHANX_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("channel reset values wrong");

  property p_setup_follows;
    (conv_timer == 16'h0000 && next_pick[4])
      |=> conv_sel.setup == $past(chan[next_pick[3:0]].setup)
      && conv_sel.input_pair == $past(chan[next_pick[3:0]].input_pair);
  endproperty
  a_setup_follows: assert property (p_setup_follows)
    else $error("selected setup or input pair wrong");

  property p_reserved_zero;
    (bus_state == adc_regs_pkg::BUS_READ && is_chan(req.index))
      |=> hrdata[11:10] == 2'h0 && hrdata[31:16] == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved channel bits not zero");

  property p_zero_readback;
    (bus_state == adc_regs_pkg::BUS_READ && req.index == `IDX_PIN_CTRL
      && pin_ctrl.in_en[0])
      |=> hrdata[0] == $past(pin_sample[0]) && hrdata[4];
  endproperty
  a_zero_readback: assert property (p_zero_readback)
    else $error("pin zero input readback wrong");

  property p_level_readback;
    (bus_state == adc_regs_pkg::BUS_READ && req.index == `IDX_PIN_CTRL
      && !pin_ctrl.in_en[1])
      |=> hrdata[1] == $past(pin_ctrl.level[1]);
  endproperty
  a_level_readback: assert property (p_level_readback)
    else $error("written pin level not read back");

  property p_pin_ctrl_write;
    (bus_state == adc_regs_pkg::BUS_WRITE && req.index == `IDX_PIN_CTRL)
      |=> pin_ctrl == $past(hwdata[5:0]);
  endproperty
  a_pin_ctrl_write: assert property (p_pin_ctrl_write)
    else $error("pin control write not stored");

  property p_gp_out_follow;
    ##1 gp_out == $past(pin_ctrl.level);
  endproperty
  a_gp_out_follow: assert property (p_gp_out_follow)
    else $error("pin drive level does not follow control");

  property p_read_wait;
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state wrong");

  property p_write_ready;
    (accept && hwrite) |=> hreadyout;
  endproperty
  a_write_ready: assert property (p_write_ready)
    else $error("write inserted a wait state");

  property p_input_pair_read;
    (bus_state == adc_regs_pkg::BUS_READ && is_chan(req.index))
      |=> hrdata[9:0] == $past(chan[chan_slot].input_pair);
  endproperty
  a_input_pair_read: assert property (p_input_pair_read)
    else $error("input pair readback wrong");

  property p_setup_read;
    (bus_state == adc_regs_pkg::BUS_READ && is_chan(req.index))
      |=> hrdata[14:12] == $past(chan[chan_slot].setup);
  endproperty
  a_setup_read: assert property (p_setup_read)
    else $error("setup selector readback wrong");

  property p_unmapped_read;
    (bus_state == adc_regs_pkg::BUS_READ && req.index != `IDX_PIN_CTRL
      && req.index != `IDX_IDENTITY && !is_chan(req.index))
      |=> hrdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_hrdata_hold;
    bus_state != adc_regs_pkg::BUS_READ |=> $stable(hrdata);
  endproperty
  a_hrdata_hold: assert property (p_hrdata_hold)
    else $error("read data changed without a read");

  property p_scan_idle;
    (conv_timer == 16'h0000 && chan_en == 16'h0000) |=> !conv_sel.valid;
  endproperty
  a_scan_idle: assert property (p_scan_idle)
    else $error("scan valid with no channel enabled");

  property p_sel_hold;
    conv_timer != 16'h0000 |=> $stable(conv_sel);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("scan selection moved between steps");

endmodule

// ---- logic/adc_regs_defines.svh ----
// named offsets, reset values and masks of the register bank
// assumes word-aligned register indices, byte address = index * 4
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

// register indices
`define IDX_PIN_CTRL 8'h06
`define IDX_IDENTITY 8'h07
`define IDX_CHAN_FIRST 8'h10
`define IDX_CHAN_LAST 8'h1F

// reset values
`define PIN_CTRL_RESET 6'h00
`define CHAN0_RESET 16'h8001
`define CHANX_RESET 16'h0001

// writable bits of a channel register
`define CHAN_WR_MASK 16'hF3FF

// channel count and bus decode
`define CHAN_COUNT 16
`define HTRANS_ACTIVE_BIT 1
`define WORD_LSB 2

`endif

// ---- logic/adc_regs_pkg.sv ----
// types shared by the register bank
// assumes nothing beyond the defines header
package adc_regs_pkg;

  typedef struct packed {
    logic enable;
    logic [2:0] setup;
    logic [1:0] reserved;
    logic [9:0] input_pair;
  } channel_cfg_t;

  typedef struct packed {
    logic [1:0] in_en;
    logic [1:0] out_en;
    logic [1:0] level;
  } pin_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [2:0] setup;
    logic [9:0] input_pair;
  } conv_sel_t;

  typedef struct packed {
    logic write;
    logic [7:0] index;
  } bus_req_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_t;

endpackage
